// file: logic/bcr_map.vh
// Constants for the BCD calendar real-time clock with backup storage
// Notes on behaviour
// - Five 32-bit backup words give 20 bytes of storage.
// - Backup words are cleared by no reset, power reset or Standby wake.
// - Time and date are kept as BCD fields, hours in 12 or 24 hour form.
// - The date rolls over at 28, 29, 30 or 31 days as month and leap year demand.
// - An alarm match raises a wake event valid in Stop and Standby.
// - A shift correction adds or removes 1 to 32767 slow-clock pulses.
// - Digital calibration trims the rate at one pulse in 2^20, about 0.954 ppm resolution.
// - Two tamper inputs each pass a software-set filter before an event counts.
// - A tamper event raises the wake output.
// - A timestamp or tamper event captures the time, weekday, date and month of the calendar, but not the year.
// - A timestamp event raises the wake output.
// - An optional 50 Hz reference realigns the seconds count.
// - The slow clock is chosen among crystal, oscillator, internal RC or fast clock over 32.
`ifndef BCR_MAP_VH
`define BCR_MAP_VH
`define BCR_NUM_BKP       5
`define BCR_PRESCALE      15
`define BCR_SUBSEC_W      15
`define BCR_SHIFT_MAX     15'h7FFF
`define BCR_CAL_PERIOD    20'hFFFFF
`define BCR_SRC_XTAL      2'h0
`define BCR_SRC_OSC       2'h1
`define BCR_SRC_RC        2'h2
`define BCR_SRC_FAST      2'h3
`define BCR_FAST_DIV      5'h1F
`define BCR_CAL_W          9
`define BCR_YEAR_RESET    8'h00
`define BCR_MONTH_RESET   8'h01
`define BCR_DATE_RESET    8'h01
`define BCR_WDAY_RESET    3'h1
`endif

// file: logic/bcr_filter.v
// Tamper input filter: input must stay high for the programmed count of samples plus one
`timescale 1ns/1ps
module bcr_filter #(
  parameter CNT_W = 4
) (
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire             tick_i,
  input  wire             pin_i,
  input  wire [CNT_W-1:0] len_i,
  output reg              event_o
);
  reg [CNT_W-1:0] count;
  reg             armed;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count   <= {CNT_W{1'b0}};
      armed   <= 1'b1;
      event_o <= 1'b0;
    end else begin
      event_o <= 1'b0;
      if (!pin_i) begin
        count <= {CNT_W{1'b0}};
        armed <= 1'b1;
      end else if (tick_i && armed) begin
        if (count >= len_i) begin
          event_o <= 1'b1;
          armed   <= 1'b0;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule

// file: logic/bcr_rtc.v
// BCD calendar real-time clock with alarm, tamper, timestamp and backup words
`timescale 1ns/1ps
`include "bcr_map.vh"
module bcr_rtc #(
  parameter NUM_BKP = `BCR_NUM_BKP,
  parameter FILT_W  = 4
) (
  input  wire                 clk_i,
  input  wire                 sys_rst_i,
  input  wire                 xtal_clk_i,
  input  wire                 osc_clk_i,
  input  wire                 rc_clk_i,
  input  wire                 fast_clk_i,
  input  wire [1:0]           clk_src_i,
  input  wire                 fmt12_i,
  input  wire                 set_i,
  input  wire [7:0]           set_sec_i,
  input  wire [7:0]           set_min_i,
  input  wire [7:0]           set_hour_i,
  input  wire                 set_pm_i,
  input  wire [2:0]           set_wday_i,
  input  wire [7:0]           set_date_i,
  input  wire [7:0]           set_month_i,
  input  wire [7:0]           set_year_i,
  input  wire                 alarm_en_i,
  input  wire [7:0]           alarm_sec_i,
  input  wire [7:0]           alarm_min_i,
  input  wire [7:0]           alarm_hour_i,
  input  wire                 alarm_pm_i,
  input  wire                 alarm_clr_i,
  input  wire                 shift_i,
  input  wire                 shift_add_i,
  input  wire [14:0]          shift_cnt_i,
  input  wire                 cal_plus_i,
  input  wire [8:0]           cal_minus_i,
  input  wire                 ref_en_i,
  input  wire                 ref_i,
  input  wire [1:0]           tamp_i,
  input  wire [1:0]           tamp_en_i,
  input  wire [FILT_W-1:0]    tamp_filt_i,
  input  wire [1:0]           tamp_clr_i,
  input  wire                 ts_i,
  input  wire                 ts_en_i,
  input  wire                 ts_clr_i,
  input  wire                 bkp_we_i,
  input  wire [2:0]           bkp_idx_i,
  input  wire [31:0]          bkp_wdata_i,
  output reg  [31:0]          bkp_rdata_o,
  output reg  [14:0]          subsec_o,
  output reg  [7:0]           sec_o,
  output reg  [7:0]           min_o,
  output reg  [7:0]           hour_o,
  output reg                  pm_o,
  output reg  [2:0]           wday_o,
  output reg  [7:0]           date_o,
  output reg  [7:0]           month_o,
  output reg  [7:0]           year_o,
  output reg                  alarm_flag_o,
  output reg  [1:0]           tamp_flag_o,
  output reg                  ts_flag_o,
  output reg  [55:0]          ts_time_o,
  output reg                  shift_busy_o,
  output wire                 wake_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Slow clock selection and edge detection
  reg [1:0] src_pipe;
  reg [4:0] fast_div;
  reg       fast_half;
  reg       fast_last;
  reg       sel_clk;
  reg [1:0] xs, os, rs, fs;
  always @* begin
    case (clk_src_i)
      `BCR_SRC_XTAL: sel_clk = xs[1];
      `BCR_SRC_OSC:  sel_clk = os[1];
      `BCR_SRC_RC:   sel_clk = rs[1];
      default:       sel_clk = fast_half;
    endcase
  end
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xs <= 2'h0; os <= 2'h0; rs <= 2'h0; fs <= 2'h0;
      fast_div <= 5'h00; fast_half <= 1'b0; fast_last <= 1'b0;
      src_pipe <= 2'h0;
    end else begin
      xs <= {xs[0], xtal_clk_i};
      os <= {os[0], osc_clk_i};
      rs <= {rs[0], rc_clk_i};
      fs <= {fs[0], fast_clk_i};
      fast_last <= fs[1];
      if (fs[1] && !fast_last) begin
        if (fast_div[3:0] == 4'hF) fast_half <= ~fast_half;
        fast_div <= fast_div + 5'h01;
      end
      src_pipe <= {src_pipe[0], sel_clk};
    end
  end
  wire slow_tick = src_pipe[0] & ~src_pipe[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler with calibration and shift correction
  reg [19:0] cal_cnt;
  reg [14:0] shift_left;
  reg        shift_add;
  reg        skip, dbl;
  reg        pend_extra;
  wire [19:0] cal_pos = cal_cnt;
  always @* begin
    skip = 1'b0;
    dbl  = 1'b0;
    // Minus pulses fall one per 2048-pulse slot in the first cal_minus_i slots of the period; plus adds 512 pulses per period
    if (cal_pos[19:11] < cal_minus_i && cal_pos[10:0] == 11'h000) skip = 1'b1;
    if (cal_plus_i && cal_pos[10:0] == 11'h400) dbl = 1'b1;
    if (shift_busy_o && !shift_add) skip = 1'b1;
    if (shift_busy_o && shift_add)  dbl = 1'b1;
  end
  wire [1:0] adv = skip ? (dbl ? 2'h1 : 2'h0) : (dbl ? 2'h2 : 2'h1);
  wire [15:0] ss_next = {1'b0, subsec_o} + {14'h0000, adv};
  wire sec_wrap = ss_next[15];

  ////////////////////////////////////////////////////////////////////////////////
  // BCD helpers
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction
  wire [7:0] yb = {4'h0, year_o[7:4]};
  wire [7:0] yr_bin = yb * 8'h0A + {4'h0, year_o[3:0]};
  wire leap = (yr_bin[1:0] == 2'b00);
  reg [7:0] month_len;
  always @* begin
    case (month_o)
      8'h02:   month_len = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference clock edge: every 50th edge steps the seconds and clears the subseconds
  reg [2:0] ref_s;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) ref_s <= 3'h0;
    else ref_s <= {ref_s[1:0], ref_i};
  end
  wire ref_edge = ref_en_i & ref_s[1] & ~ref_s[2];
  reg [5:0] ref_cnt;
  wire ref_sec = ref_edge && (ref_cnt == 6'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // Calendar
  wire       sec_step = slow_tick & sec_wrap & ~ref_en_i | ref_sec;
  wire [7:0] h_max = fmt12_i ? 8'h12 : 8'h23;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      subsec_o <= 15'h0000; sec_o <= 8'h00; min_o <= 8'h00;
      hour_o <= 8'h00; pm_o <= 1'b0; wday_o <= `BCR_WDAY_RESET;
      date_o <= `BCR_DATE_RESET; month_o <= `BCR_MONTH_RESET;
      year_o <= `BCR_YEAR_RESET; cal_cnt <= 20'h00000;
      shift_left <= 15'h0000; shift_add <= 1'b0; shift_busy_o <= 1'b0;
      ref_cnt <= 6'h00;
    end else if (set_i) begin
      sec_o <= set_sec_i; min_o <= set_min_i; hour_o <= set_hour_i;
      pm_o <= set_pm_i; wday_o <= set_wday_i; date_o <= set_date_i;
      month_o <= set_month_i; year_o <= set_year_i; subsec_o <= 15'h0000;
    end else begin
      if (shift_i && !shift_busy_o && shift_cnt_i != 15'h0000) begin
        shift_left <= shift_cnt_i;
        shift_add <= shift_add_i;
        shift_busy_o <= 1'b1;
      end
      if (ref_edge) ref_cnt <= (ref_cnt == 6'h31) ? 6'h00 : ref_cnt + 6'h01;
      if (slow_tick) begin
        cal_cnt <= cal_cnt + 20'h00001;
        if (shift_busy_o) begin
          shift_left <= shift_left - 15'h0001;
          if (shift_left == 15'h0001) shift_busy_o <= 1'b0;
        end
        subsec_o <= ss_next[14:0];
      end
      if (ref_sec) subsec_o <= 15'h0000;
      if (sec_step) begin
        if (sec_o == 8'h59) begin
          sec_o <= 8'h00;
          if (min_o == 8'h59) begin
            min_o <= 8'h00;
            if (fmt12_i && hour_o == 8'h11) pm_o <= ~pm_o;
            if (hour_o == h_max) begin
              hour_o <= fmt12_i ? 8'h01 : 8'h00;
            end else begin
              hour_o <= bcd_inc(hour_o);
            end
            if (!fmt12_i && hour_o == 8'h23 || fmt12_i && pm_o && hour_o == 8'h11) begin
              wday_o <= (wday_o == 3'h7) ? 3'h1 : wday_o + 3'h1;
              if (date_o == month_len) begin
                date_o <= 8'h01;
                if (month_o == 8'h12) begin
                  month_o <= 8'h01;
                  year_o <= (year_o == 8'h99) ? 8'h00 : bcd_inc(year_o);
                end else begin
                  month_o <= bcd_inc(month_o);
                end
              end else begin
                date_o <= bcd_inc(date_o);
              end
            end
          end else begin
            min_o <= bcd_inc(min_o);
          end
        end else begin
          sec_o <= bcd_inc(sec_o);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tamper filters, timestamp and alarm flags
  wire [1:0] tamp_ev;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_tamp
      bcr_filter #(.CNT_W(FILT_W)) u_filt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (slow_tick),
        .pin_i     (tamp_i[g] & tamp_en_i[g]),
        .len_i     (tamp_filt_i),
        .event_o   (tamp_ev[g])
      );
    end
  endgenerate
  reg ts_last;
  reg sec_moved;
  wire ts_ev = ts_en_i & ts_i & ~ts_last;
  // Compare the time just reached, one cycle after the seconds step
  wire alarm_hit = alarm_en_i && sec_moved && sec_o == alarm_sec_i && min_o == alarm_min_i
                   && hour_o == alarm_hour_i && (!fmt12_i || pm_o == alarm_pm_i);
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ts_last <= 1'b0; alarm_flag_o <= 1'b0; tamp_flag_o <= 2'h0;
      ts_flag_o <= 1'b0; ts_time_o <= 56'h0; sec_moved <= 1'b0;
    end else begin
      ts_last <= ts_i;
      sec_moved <= sec_step & ~set_i;
      alarm_flag_o <= alarm_hit | (alarm_flag_o & ~alarm_clr_i);
      tamp_flag_o <= tamp_ev | (tamp_flag_o & ~tamp_clr_i);
      ts_flag_o <= ts_ev | (ts_flag_o & ~ts_clr_i);
      if (ts_ev || tamp_ev != 2'h0) begin
        ts_time_o <= {8'h00, pm_o, wday_o, 4'h0, month_o, date_o, hour_o, min_o, sec_o};
      end
    end
  end
  assign wake_o = alarm_flag_o | ts_flag_o | (|tamp_flag_o);

  ////////////////////////////////////////////////////////////////////////////////
  // Backup words: not on the system reset, so they keep contents across resets
  reg [31:0] bkp [0:NUM_BKP-1];
  always @(posedge clk_i) begin
    if (bkp_we_i && bkp_idx_i < NUM_BKP) bkp[bkp_idx_i] <= bkp_wdata_i;
  end
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) bkp_rdata_o <= 32'h00000000;
    else bkp_rdata_o <= (bkp_idx_i < NUM_BKP) ? bkp[bkp_idx_i] : 32'h00000000;
  end
endmodule

// file: dv/bcr_rtc_chk.sv
// Port assertions for the BCD calendar clock
`timescale 1ns/1ps
module bcr_rtc_chk #(
  parameter NUM_BKP = 5
) (
  input wire        clk_i,
  input wire        sys_rst_i,
  input wire        set_i,
  input wire [7:0]  set_sec_i,
  input wire [7:0]  sec_o,
  input wire [14:0] subsec_o,
  input wire [7:0]  date_o,
  input wire        alarm_clr_i,
  input wire        alarm_flag_o,
  input wire        ts_clr_i,
  input wire        ts_flag_o,
  input wire [1:0]  tamp_flag_o,
  input wire        wake_o,
  input wire        shift_i,
  input wire [14:0] shift_cnt_i,
  input wire        shift_busy_o,
  input wire [2:0]  bkp_idx_i,
  input wire [31:0] bkp_rdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_shift_idle;
    shift_i && !shift_busy_o;
  endsequence
  sequence s_shift_go;
    s_shift_idle ##0 shift_cnt_i != 15'h0;
  endsequence
  a_set_loads: assert property (set_i |=> sec_o == $past(set_sec_i) && subsec_o == 15'h0)
    else $error("set value not loaded");
  a_sec_bcd: assert property (sec_o[3:0] <= 4'h9 && sec_o <= 8'h59)
    else $error("seconds not bcd");
  a_date_range: assert property (date_o != 8'h00 && date_o <= 8'h31)
    else $error("date out of range");
  a_alarm_sticky: assert property ($fell(alarm_flag_o) |-> $past(alarm_clr_i))
    else $error("alarm flag dropped");
  a_ts_sticky: assert property ($fell(ts_flag_o) |-> $past(ts_clr_i))
    else $error("stamp flag dropped");
  a_wake_flags: assert property (wake_o == (alarm_flag_o | (|tamp_flag_o) | ts_flag_o))
    else $error("wake not tied to flags");
  a_bkp_unmapped: assert property (bkp_idx_i >= NUM_BKP |=> bkp_rdata_o == 32'h0)
    else $error("unmapped word not zero");
  a_shift_start: assert property (s_shift_go |=> shift_busy_o)
    else $error("shift not started");
  a_shift_zero: assert property (s_shift_idle ##0 shift_cnt_i == 15'h0 |=> !shift_busy_o)
    else $error("zero shift started");
endmodule
bind bcr_rtc bcr_rtc_chk #(.NUM_BKP(NUM_BKP)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .set_i(set_i), .set_sec_i(set_sec_i), .sec_o(sec_o), .subsec_o(subsec_o), .date_o(date_o),
  .alarm_clr_i(alarm_clr_i), .alarm_flag_o(alarm_flag_o), .ts_clr_i(ts_clr_i),
  .ts_flag_o(ts_flag_o), .tamp_flag_o(tamp_flag_o), .wake_o(wake_o), .shift_i(shift_i),
  .shift_cnt_i(shift_cnt_i), .shift_busy_o(shift_busy_o), .bkp_idx_i(bkp_idx_i),
  .bkp_rdata_o(bkp_rdata_o));

// file: dv/bcr_rtc_test.sv
// Self-checking bench for the BCD calendar clock
`timescale 1ns/1ps
module bcr_rtc_test;
  reg         clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg         slow = 1'b0;
  reg         fast = 1'b0;
  reg  [1:0]  clk_src_i, tamp_i, tamp_en_i, tamp_clr_i;
  reg         fmt12_i, set_i, set_pm_i, alarm_en_i, alarm_pm_i, alarm_clr_i, shift_i;
  reg         shift_add_i, ref_en_i, ref_i, ts_i, ts_en_i, ts_clr_i, bkp_we_i;
  reg  [7:0]  set_sec_i, set_min_i, set_hour_i, set_date_i, set_month_i, set_year_i;
  reg  [7:0]  alarm_sec_i, alarm_min_i, alarm_hour_i;
  reg  [2:0]  set_wday_i, bkp_idx_i;
  reg  [14:0] shift_cnt_i;
  reg  [3:0]  tamp_filt_i;
  reg  [31:0] bkp_wdata_i;
  wire [31:0] bkp_rdata_o;
  wire [14:0] subsec_o;
  wire [7:0]  sec_o, min_o, hour_o, date_o, month_o, year_o;
  wire [2:0]  wday_o;
  wire [1:0]  tamp_flag_o;
  wire [55:0] ts_time_o;
  wire        pm_o, alarm_flag_o, ts_flag_o, shift_busy_o, wake_o;
  integer     fail_count = 0;
  integer     n_checks = 0;
  integer     k;
  initial forever #12.5 clk_i = ~clk_i;
  initial forever #200 slow = ~slow;
  initial forever #50 fast = ~fast;
  bcr_rtc DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .xtal_clk_i(slow), .osc_clk_i(slow),
    .rc_clk_i(slow), .fast_clk_i(fast), .clk_src_i(clk_src_i), .fmt12_i(fmt12_i),
    .set_i(set_i), .set_sec_i(set_sec_i), .set_min_i(set_min_i), .set_hour_i(set_hour_i),
    .set_pm_i(set_pm_i), .set_wday_i(set_wday_i), .set_date_i(set_date_i),
    .set_month_i(set_month_i), .set_year_i(set_year_i), .alarm_en_i(alarm_en_i),
    .alarm_sec_i(alarm_sec_i), .alarm_min_i(alarm_min_i), .alarm_hour_i(alarm_hour_i),
    .alarm_pm_i(alarm_pm_i), .alarm_clr_i(alarm_clr_i), .shift_i(shift_i),
    .shift_add_i(shift_add_i), .shift_cnt_i(shift_cnt_i), .cal_plus_i(1'b0),
    .cal_minus_i(9'h000), .ref_en_i(ref_en_i), .ref_i(ref_i), .tamp_i(tamp_i),
    .tamp_en_i(tamp_en_i), .tamp_filt_i(tamp_filt_i), .tamp_clr_i(tamp_clr_i), .ts_i(ts_i),
    .ts_en_i(ts_en_i), .ts_clr_i(ts_clr_i), .bkp_we_i(bkp_we_i), .bkp_idx_i(bkp_idx_i),
    .bkp_wdata_i(bkp_wdata_i), .bkp_rdata_o(bkp_rdata_o), .subsec_o(subsec_o), .sec_o(sec_o),
    .min_o(min_o), .hour_o(hour_o), .pm_o(pm_o), .wday_o(wday_o), .date_o(date_o),
    .month_o(month_o), .year_o(year_o), .alarm_flag_o(alarm_flag_o),
    .tamp_flag_o(tamp_flag_o), .ts_flag_o(ts_flag_o), .ts_time_o(ts_time_o),
    .shift_busy_o(shift_busy_o), .wake_o(wake_o));
  ////////////////////////////////////////////////////////////////////////////
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task set_cal(input [7:0] y, m, d, h, mi, s);
    {set_year_i, set_month_i, set_date_i, set_hour_i, set_min_i, set_sec_i} = {y, m, d, h, mi, s};
    set_i = 1'b1;
    tick(1);
    set_i = 1'b0;
  endtask
  // Fifty reference edges make one second
  task step_sec;
    repeat (50) begin
      ref_i = 1'b1;
      tick(2);
      ref_i = 1'b0;
      tick(2);
    end
    tick(4);
  endtask
  task roll(input [7:0] y, m, d, ey, em, ed);
    set_cal(y, m, d, 8'h23, 8'h59, 8'h59);
    chk({year_o, month_o, date_o, hour_o, min_o, sec_o}, {y, m, d, 24'h235959});
    step_sec;
    chk({year_o, month_o, date_o, hour_o, min_o, sec_o, wday_o}, {ey, em, ed, 24'h0, 3'h2});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_calendar;
    roll(8'h00, 8'h02, 8'h28, 8'h00, 8'h02, 8'h29);
    roll(8'h00, 8'h02, 8'h29, 8'h00, 8'h03, 8'h01);
    roll(8'h01, 8'h02, 8'h28, 8'h01, 8'h03, 8'h01);
    roll(8'h01, 8'h04, 8'h30, 8'h01, 8'h05, 8'h01);
    roll(8'h99, 8'h12, 8'h31, 8'h00, 8'h01, 8'h01);
    $display("calendar done");
  endtask
  task t_alarm;
    {fmt12_i, set_pm_i, set_wday_i} = {2'b10, 3'h2};
    {alarm_hour_i, alarm_min_i, alarm_sec_i, alarm_pm_i, alarm_en_i} = {24'h120000, 2'b11};
    set_cal(8'h24, 8'h06, 8'h15, 8'h11, 8'h59, 8'h59);
    chk(alarm_flag_o, 1'b0);
    step_sec;
    chk({pm_o, hour_o, min_o, sec_o, alarm_flag_o, wake_o}, {1'b1, 24'h120000, 2'b11});
    alarm_clr_i = 1'b1;
    tick(1);
    alarm_clr_i = 1'b0;
    chk({alarm_flag_o, wake_o}, 2'b00);
    $display("alarm done");
  endtask
  task t_tamper;
    {tamp_en_i, tamp_filt_i, tamp_i} = {2'b11, 4'h2, 2'b10};
    tick(6);
    tamp_i = 2'b00;
    tick(64);
    chk(tamp_flag_o, 2'b00);
    tamp_i = 2'b01;
    tick(160);
    chk({tamp_flag_o, wake_o}, 3'b011);
    chk(ts_time_o, {1'b1, 3'h2, 4'h0, 40'h0615120000});
    {tamp_i, tamp_clr_i, ts_clr_i} = {2'b00, 2'b11, 1'b1};
    tick(1);
    {tamp_clr_i, ts_clr_i} = 3'b000;
    chk({tamp_flag_o, ts_flag_o, wake_o}, 4'h0);
    $display("tamper done");
  endtask
  task t_stamp;
    ts_en_i = 1'b1;
    step_sec;
    ts_i = 1'b1;
    tick(6);
    ts_i = 1'b0;
    tick(20);
    chk({ts_flag_o, wake_o, ts_time_o}, {2'b11, 8'h00, 1'b1, 3'h2, 4'h0, 40'h0615120001});
    ts_clr_i = 1'b1;
    tick(1);
    ts_clr_i = 1'b0;
    chk(ts_flag_o, 1'b0);
    $display("stamp done");
  endtask
  task t_shift;
    shift_i = 1'b1;
    tick(1);
    shift_i = 1'b0;
    chk(shift_busy_o, 1'b0);
    {shift_cnt_i, shift_add_i, shift_i} = {15'h0001, 2'b11};
    tick(1);
    shift_i = 1'b0;
    chk(shift_busy_o, 1'b1);
    for (k = 0; k < 400 && shift_busy_o !== 1'b0; k = k + 1) tick(1);
    chk(shift_busy_o, 1'b0);
    $display("shift done");
    if (k == 400) begin
      fail_count = fail_count + 1;
      conclude;
    end
  endtask
  task t_backup;
    bkp_we_i = 1'b1;
    for (k = 0; k < 5; k = k + 1) begin
      {bkp_idx_i, bkp_wdata_i} = {k[2:0], 28'h5A5A000, k[3:0]};
      tick(1);
    end
    {bkp_we_i, sys_rst_i} = 2'b01;
    tick(10);
    sys_rst_i = 1'b0;
    chk({year_o, month_o, date_o, sec_o}, 32'h00010100);
    for (k = 0; k < 8; k = k + 1) begin
      bkp_idx_i = k[2:0];
      tick(1);
      chk(bkp_rdata_o, k < 5 ? {28'h5A5A000, k[3:0]} : 32'h0);
    end
    $display("backup done");
  endtask
  // Cycles between two subsecond steps give the slow clock period
  task t_source(input [1:0] src, input integer exp);
    integer n;
    clk_src_i = src;
    tick(300);
    n = subsec_o;
    for (k = 0; k < 400 && subsec_o == n; k = k + 1) tick(1);
    n = subsec_o;
    for (k = 0; k < 400 && subsec_o == n; k = k + 1) tick(1);
    chk(k, exp);
    $display("source done");
  endtask
  initial begin
    {clk_src_i, tamp_i, tamp_en_i, tamp_clr_i, fmt12_i, set_i, set_pm_i, alarm_en_i,
     alarm_pm_i, alarm_clr_i, shift_i, shift_add_i, ref_i, ts_i, ts_en_i, ts_clr_i,
     bkp_we_i, set_sec_i, set_min_i, set_hour_i, set_date_i, set_month_i, set_year_i,
     alarm_sec_i, alarm_min_i, alarm_hour_i, bkp_idx_i, shift_cnt_i, tamp_filt_i,
     bkp_wdata_i} = 0;
    {set_wday_i, ref_en_i} = 4'h3;
    tick(10);
    sys_rst_i = 1'b0;
    t_calendar;
    t_alarm;
    t_tamper;
    t_stamp;
    t_shift;
    t_backup;
    t_source(2'h3, 128);
    t_source(2'h0, 16);
    conclude;
  end
endmodule
